// File: enc_out_cfg.svh
// register offsets, reset values and timing counts for the divided output
`ifndef ENC_OUT_CFG_SVH
`define ENC_OUT_CFG_SVH

`define ADDR_DIR_REV      16'h2000
`define ADDR_ORIGIN_DIR   16'h2081
`define ADDR_PPR          16'h2212
`define ADDR_LIN_RES      16'h2281
`define ADDR_ENC_RES      16'h3000
`define ADDR_PITCH_CNT    16'h3004
`define ADDR_CTRL         16'h3008
`define ADDR_STATUS       16'h300c

`define CTRL_RESTART_BIT  0
`define CTRL_LINEAR_BIT   1
`define ORIGIN_BOTH_BIT   0
`define DIR_REV_BIT       0

`define RST_ORIGIN_DIR    16'h0000
`define RST_DIR_REV       16'h0000
`define RST_PPR           32'h0000_0800
`define RST_LIN_RES       32'h0000_0014
`define RST_ENC_RES       32'h0010_0000
`define RST_PITCH_CNT     32'h0000_0100

`define PITCH_SHIFT_LOG2  3
`define ORIGIN_WIDE_STEPS 2'h2
`define ORIGIN_NARROW_STEPS 2'h1

`endif

// File: enc_out_pkg.sv
// types shared by the divided quadrature output block
package enc_out_pkg;

  typedef logic [31:0] word_t;

  typedef enum logic [1:0] {
    ORG_IDLE,
    ORG_SHIFT,
    ORG_PULSE
  } org_state_e;

endpackage

// File: quad_step.sv
// quadrature state stepper with registered complementary a/b outputs
`timescale 1ns/1ps
module quad_step
  import enc_out_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic step_fwd,
  input  wire logic step_rev,
  output logic      phase_out [2],
  output logic      phase_out_n [2],
  output logic [1:0] state
);

  logic [1:0] state_q;
  logic [1:0] state_d;
  logic [1:0] ab_d;

  // phase level for a state index: index 0 is a, index 1 is b
  function automatic logic phase_level(input logic [1:0] s, input int idx);
    if (idx == 0) begin
      return s[1];
    end
    return s[1] ^ s[0];
  endfunction

  always_comb begin
    state_d = state_q;
    if (step_fwd) begin
      state_d = state_q + 2'h1; // b leads a
    end else if (step_rev) begin
      state_d = state_q - 2'h1; // a leads b
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= 2'h0;
    end else begin
      state_q <= state_d;
    end
  end

  assign state = state_q;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_phase
      always_comb begin
        ab_d[g] = phase_level(state_d, g);
      end
      // complementary pair per phase
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          phase_out[g]   <= 1'b0;
          phase_out_n[g] <= 1'b1;
        end else begin
          phase_out[g]   <= ab_d[g];
          phase_out_n[g] <= ~ab_d[g];
        end
      end
    end
  endgenerate

endmodule

// File: encoder_divided_quadrature_output.sv
// divided encoder feedback: scaled quadrature a/b plus origin pulse
`timescale 1ns/1ps
`include "enc_out_cfg.svh"
module encoder_divided_quadrature_output
  import enc_out_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int ACC_W  = 35
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [31:0]       wr_data,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic      [31:0]       rd_data,
  input  wire logic              enc_step,
  input  wire logic              enc_dir_up,
  input  wire logic              enc_origin,
  output logic                   quad_phase_a_out,
  output logic                   quad_phase_a_out_n,
  output logic                   quad_phase_b_out,
  output logic                   quad_phase_b_out_n,
  output logic                   origin_pulse_out,
  output logic                   origin_pulse_out_n
);

  // software-visible settings
  logic [15:0] origin_direction_select_q;
  logic [15:0] origin_direction_select_d;
  logic [15:0] direction_reversal_setting_q;
  logic [15:0] direction_reversal_setting_d;
  word_t       pulses_per_rev_setting_q;
  word_t       pulses_per_rev_setting_d;
  word_t       linear_output_resolution_q;
  word_t       linear_output_resolution_d;
  word_t       enc_counts_per_rev_q;
  word_t       enc_counts_per_rev_d;
  word_t       pitch_counts_q;
  word_t       pitch_counts_d;
  logic        linear_sel_q;
  logic        linear_sel_d;
  word_t       rd_data_q;
  word_t       rd_data_d;
  logic        restart;

  // settings in force since the last restart
  logic [ACC_W-1:0] act_num_q;
  logic [ACC_W-1:0] act_num_d;
  logic [ACC_W-1:0] act_den_q;
  logic [ACC_W-1:0] act_den_d;
  logic             act_both_q;
  logic             act_both_d;
  logic             act_lin_q;
  logic             act_lin_d;

  // divider
  logic signed [ACC_W-1:0] acc_q;
  logic signed [ACC_W-1:0] acc_d;
  logic signed [ACC_W-1:0] acc_tmp;
  logic                    step_fwd;
  logic                    step_rev;

  // origin path
  org_state_e       org_q;
  org_state_e       org_d;
  logic [ACC_W-1:0] shift_cnt_q;
  logic [ACC_W-1:0] shift_cnt_d;
  logic             shift_dir_q;
  logic             shift_dir_d;
  logic [1:0]       width_q;
  logic [1:0]       width_d;
  logic             seen_fwd_q;
  logic             seen_fwd_d;
  logic             org_out_d;

  logic       ph_out   [2];
  logic       ph_out_n [2];
  logic [1:0] quad_state;

  assign restart = wr_en && (addr == `ADDR_CTRL)
                   && wr_data[`CTRL_RESTART_BIT];

  // register writes and reads
  always_comb begin
    origin_direction_select_d    = origin_direction_select_q;
    direction_reversal_setting_d = direction_reversal_setting_q;
    pulses_per_rev_setting_d     = pulses_per_rev_setting_q;
    linear_output_resolution_d   = linear_output_resolution_q;
    enc_counts_per_rev_d         = enc_counts_per_rev_q;
    pitch_counts_d               = pitch_counts_q;
    linear_sel_d                 = linear_sel_q;
    rd_data_d                    = 32'h0000_0000;
    if (wr_en) begin
      case (addr)
        `ADDR_ORIGIN_DIR: origin_direction_select_d = wr_data[15:0];
        `ADDR_DIR_REV:    direction_reversal_setting_d = wr_data[15:0];
        `ADDR_PPR:        pulses_per_rev_setting_d = wr_data;
        `ADDR_LIN_RES:    linear_output_resolution_d = wr_data;
        `ADDR_ENC_RES:    enc_counts_per_rev_d = wr_data;
        `ADDR_PITCH_CNT:  pitch_counts_d = wr_data;
        `ADDR_CTRL:       linear_sel_d = wr_data[`CTRL_LINEAR_BIT];
        default: ;
      endcase
    end
    if (rd_en) begin
      case (addr)
        `ADDR_ORIGIN_DIR: rd_data_d = {16'h0000, origin_direction_select_q};
        `ADDR_DIR_REV:    rd_data_d = {16'h0000, direction_reversal_setting_q};
        `ADDR_PPR:        rd_data_d = pulses_per_rev_setting_q;
        `ADDR_LIN_RES:    rd_data_d = linear_output_resolution_q;
        `ADDR_ENC_RES:    rd_data_d = enc_counts_per_rev_q;
        `ADDR_PITCH_CNT:  rd_data_d = pitch_counts_q;
        `ADDR_CTRL:       rd_data_d = {30'h0, linear_sel_q, 1'b0};
        `ADDR_STATUS:     rd_data_d = {26'h0, org_q == ORG_PULSE,
                                       act_lin_q, act_both_q,
                                       seen_fwd_q, quad_state};
        default:          rd_data_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      origin_direction_select_q    <= `RST_ORIGIN_DIR;
      direction_reversal_setting_q <= `RST_DIR_REV;
      pulses_per_rev_setting_q     <= `RST_PPR;
      linear_output_resolution_q   <= `RST_LIN_RES;
      enc_counts_per_rev_q         <= `RST_ENC_RES;
      pitch_counts_q               <= `RST_PITCH_CNT;
      linear_sel_q                 <= 1'b0;
      rd_data_q                    <= 32'h0000_0000;
    end else begin
      origin_direction_select_q    <= origin_direction_select_d;
      direction_reversal_setting_q <= direction_reversal_setting_d;
      pulses_per_rev_setting_q     <= pulses_per_rev_setting_d;
      linear_output_resolution_q   <= linear_output_resolution_d;
      enc_counts_per_rev_q         <= enc_counts_per_rev_d;
      pitch_counts_q               <= pitch_counts_d;
      linear_sel_q                 <= linear_sel_d;
      rd_data_q                    <= rd_data_d;
    end
  end

  assign rd_data = rd_data_q;

  // settings take effect only at restart; reversal setting is not used
  always_comb begin
    act_num_d  = act_num_q;
    act_den_d  = act_den_q;
    act_both_d = act_both_q;
    act_lin_d  = act_lin_q;
    if (restart) begin
      act_lin_d  = linear_sel_q;
      act_both_d = origin_direction_select_q[`ORIGIN_BOTH_BIT];
      if (linear_sel_q) begin
        act_num_d = ACC_W'(linear_output_resolution_q);
        act_den_d = ACC_W'(pitch_counts_q);
      end else begin
        act_num_d = ACC_W'({pulses_per_rev_setting_q, 2'b00});
        act_den_d = ACC_W'(enc_counts_per_rev_q);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      act_num_q  <= ACC_W'({`RST_PPR, 2'b00});
      act_den_q  <= ACC_W'(`RST_ENC_RES);
      act_both_q <= 1'b0;
      act_lin_q  <= 1'b0;
    end else begin
      act_num_q  <= act_num_d;
      act_den_q  <= act_den_d;
      act_both_q <= act_both_d;
      act_lin_q  <= act_lin_d;
    end
  end

  // fractional divider: one output edge per den/num encoder counts
  always_comb begin
    acc_d    = acc_q;
    acc_tmp  = acc_q;
    step_fwd = 1'b0;
    step_rev = 1'b0;
    if (restart) begin
      acc_d = '0;
    end else if (enc_step) begin
      if (enc_dir_up) begin
        acc_tmp = acc_q + $signed(act_num_q);
        if (acc_tmp >= $signed(act_den_q)) begin
          acc_d    = acc_tmp - $signed(act_den_q);
          step_fwd = 1'b1;
        end else begin
          acc_d = acc_tmp;
        end
      end else begin
        acc_tmp = acc_q - $signed(act_num_q);
        if (acc_tmp < 0) begin
          acc_d    = acc_tmp + $signed(act_den_q);
          step_rev = 1'b1;
        end else begin
          acc_d = acc_tmp;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_q <= '0;
    end else begin
      acc_q <= acc_d;
    end
  end

  // origin detection, gating and pulse width
  always_comb begin
    org_d       = org_q;
    shift_cnt_d = shift_cnt_q;
    shift_dir_d = shift_dir_q;
    width_d     = width_q;
    seen_fwd_d  = seen_fwd_q;
    case (org_q)
      ORG_IDLE: begin
        // handling depends on act_both_q, count direction, seen_fwd_q and act_lin_q
        if (enc_origin) begin
          if (act_both_q) begin
            // detection moved by an eighth of act_den_q: an eighth pitch in linear mode, an eighth rev otherwise
            shift_cnt_d = act_den_q >> `PITCH_SHIFT_LOG2;
            shift_dir_d = enc_dir_up;
            org_d       = ORG_SHIFT;
            if ((act_den_q >> `PITCH_SHIFT_LOG2) == '0) begin
              width_d = `ORIGIN_NARROW_STEPS;
              org_d   = ORG_PULSE;
            end
          end else if (enc_dir_up || seen_fwd_q || !act_lin_q) begin
            // gated on count direction, seen_fwd_q and act_lin_q
            width_d = `ORIGIN_WIDE_STEPS;
            org_d   = ORG_PULSE;
          end
          if (enc_dir_up) begin
            seen_fwd_d = 1'b1;
          end
        end
      end
      ORG_SHIFT: begin
        if (enc_step) begin
          if (enc_dir_up != shift_dir_q) begin
            org_d = ORG_IDLE;
          end else if (shift_cnt_q <= 1) begin
            width_d = `ORIGIN_NARROW_STEPS;
            org_d   = ORG_PULSE;
          end else begin
            shift_cnt_d = shift_cnt_q - 1'b1;
          end
        end
      end
      ORG_PULSE: begin
        // ends on the width_q-th output step of either phase
        if (step_fwd || step_rev) begin
          if (width_q <= 2'h1) begin
            org_d = ORG_IDLE;
          end else begin
            width_d = width_q - 2'h1;
          end
        end
      end
      default: org_d = ORG_IDLE;
    endcase
    if (restart) begin
      org_d      = ORG_IDLE;
      seen_fwd_d = 1'b0;
    end
    org_out_d = (org_d == ORG_PULSE);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      org_q              <= ORG_IDLE;
      shift_cnt_q        <= '0;
      shift_dir_q        <= 1'b0;
      width_q            <= 2'h0;
      seen_fwd_q         <= 1'b0;
      origin_pulse_out   <= 1'b0;
      origin_pulse_out_n <= 1'b1;
    end else begin
      org_q              <= org_d;
      shift_cnt_q        <= shift_cnt_d;
      shift_dir_q        <= shift_dir_d;
      width_q            <= width_d;
      seen_fwd_q         <= seen_fwd_d;
      origin_pulse_out   <= org_out_d;
      origin_pulse_out_n <= ~org_out_d;
    end
  end

  // phases follow physical count direction only
  quad_step u_quad (
    .clk         (clk),
    .rst_n       (rst_n),
    .step_fwd    (step_fwd),
    .step_rev    (step_rev),
    .phase_out   (ph_out),
    .phase_out_n (ph_out_n),
    .state       (quad_state)
  );

  // straight wires from the stepper's output flops
  assign quad_phase_a_out   = ph_out[0];
  assign quad_phase_a_out_n = ph_out_n[0];
  assign quad_phase_b_out   = ph_out[1];
  assign quad_phase_b_out_n = ph_out_n[1];

endmodule

// File: enc_out_chk.sv
// port assertions for the divided quadrature output
`timescale 1ns/1ps
`include "enc_out_cfg.svh"
module enc_out_chk
  import enc_out_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int ACC_W  = 35
) (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0]       wr_data,
  input wire logic              wr_en,
  input wire logic              rd_en,
  input wire logic [31:0]       rd_data,
  input wire logic              enc_step,
  input wire logic              enc_dir_up,
  input wire logic              enc_origin,
  input wire logic              quad_phase_a_out,
  input wire logic              quad_phase_a_out_n,
  input wire logic              quad_phase_b_out,
  input wire logic              quad_phase_b_out_n,
  input wire logic              origin_pulse_out,
  input wire logic              origin_pulse_out_n
);
  logic [1:0] qs;
  logic [1:0] cnt_q;
  logic       reg_both_q;
  logic       reg_lin_q;
  logic       both_q;
  logic       lin_q;
  logic       seen_q;
  logic       restart;
  assign qs = {quad_phase_a_out, quad_phase_a_out ^ quad_phase_b_out};
  assign restart = wr_en && addr == `ADDR_CTRL && wr_data[0];
  // shadow of the active mode, loaded at restart from the stored settings
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_both_q <= 1'b0;
      reg_lin_q  <= 1'b0;
      both_q     <= 1'b0;
      lin_q      <= 1'b0;
      seen_q     <= 1'b0;
      cnt_q      <= 2'h0;
    end else begin
      if (wr_en && addr == `ADDR_ORIGIN_DIR) begin
        reg_both_q <= wr_data[0];
      end
      if (wr_en && addr == `ADDR_CTRL) begin
        reg_lin_q <= wr_data[1];
      end
      if (restart) begin
        both_q <= reg_both_q;
        lin_q  <= reg_lin_q;
        seen_q <= 1'b0;
      end else if (enc_origin && enc_dir_up) begin
        seen_q <= 1'b1;
      end
      if (!origin_pulse_out) begin
        cnt_q <= 2'h0;
      end else if (!$rose(origin_pulse_out) && $changed(qs)) begin
        cnt_q <= cnt_q + 2'h1;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_a_compl: assert property (quad_phase_a_out_n == !quad_phase_a_out)
    else $error("phase a pair not complementary");
  a_b_compl: assert property (quad_phase_b_out_n == !quad_phase_b_out)
    else $error("phase b pair not complementary");
  a_c_compl: assert property (origin_pulse_out_n == !origin_pulse_out)
    else $error("origin pair not complementary");
  a_no_skip: assert property (!($changed(quad_phase_a_out) &&
    $changed(quad_phase_b_out))) else $error("a and b moved together");
  a_step_cause: assert property ($changed(qs) |-> $past(enc_step))
    else $error("output step without encoder count");
  a_dir_order: assert property (($changed(qs) && $past(rst_n)) |->
    qs == ($past(enc_dir_up) ? $past(qs) + 2'h1 : $past(qs) - 2'h1))
    else $error("quadrature order wrong");
  a_org_start: assert property ((!both_q && enc_origin && enc_dir_up &&
    !origin_pulse_out && !wr_en) |=> origin_pulse_out)
    else $error("forward origin gave no pulse");
  a_org_width: assert property (($fell(origin_pulse_out) && !$past(wr_en))
    |-> ($changed(qs) && cnt_q == (both_q ? 2'h0 : 2'h1)))
    else $error("origin pulse width wrong");
  a_lin_gate: assert property ((lin_q && !both_q && !seen_q && enc_origin
    && !enc_dir_up && !origin_pulse_out) |=> !origin_pulse_out)
    else $error("first reverse origin not suppressed");
  a_rd_idle: assert property (!$past(rd_en) |-> rd_data == 32'h0)
    else $error("read data outside read slot");
  c_both: cover property ($rose(origin_pulse_out) && both_q);
  c_rev: cover property ($changed(qs) && !$past(enc_dir_up));
  c_gate: cover property (lin_q && enc_origin && !enc_dir_up && !seen_q);
endmodule

bind encoder_divided_quadrature_output enc_out_chk #(
  .ADDR_W(ADDR_W), .ACC_W(ACC_W)
) u_chk (
  .clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
  .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .enc_step(enc_step),
  .enc_dir_up(enc_dir_up), .enc_origin(enc_origin),
  .quad_phase_a_out(quad_phase_a_out),
  .quad_phase_a_out_n(quad_phase_a_out_n),
  .quad_phase_b_out(quad_phase_b_out),
  .quad_phase_b_out_n(quad_phase_b_out_n),
  .origin_pulse_out(origin_pulse_out),
  .origin_pulse_out_n(origin_pulse_out_n)
);

// File: quad_host.sv
// host model counting quadrature feedback and origin pulses
`timescale 1ns/1ps
module quad_host (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          pha,
  input  wire logic          pha_n,
  input  wire logic          phb,
  input  wire logic          phb_n,
  input  wire logic          org,
  input  wire logic          org_n,
  output logic signed [31:0] pos,
  output logic [15:0]        org_cnt,
  output logic [15:0]        bad_cnt
);
  logic [1:0] s;
  logic [1:0] s_q;
  logic       org_q;
  assign s = {pha, pha ^ phb};
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q     <= 2'h0;
      org_q   <= 1'b0;
      pos     <= 32'sh0;
      org_cnt <= 16'h0;
      bad_cnt <= 16'h0;
    end else begin
      s_q   <= s;
      org_q <= org;
      if (s == s_q + 2'h1) pos <= pos + 32'sh1;
      if (s == s_q - 2'h1) pos <= pos - 32'sh1;
      if (s == s_q + 2'h2 || pha_n == pha || phb_n == phb || org_n == org)
        bad_cnt <= bad_cnt + 16'h1;
      if (org && !org_q) org_cnt <= org_cnt + 16'h1;
    end
  end
endmodule

// File: testbench.sv
// self-checking bench for the divided quadrature output
`timescale 1ns/1ps
`include "enc_out_cfg.svh"
module testbench
  import enc_out_pkg::*;
;
  logic               clk, rst_n, wr_en, rd_en, enc_step, enc_dir_up;
  logic               enc_origin, pa, pa_n, pb, pb_n, pc, pc_n;
  logic [15:0]        addr;
  word_t              wr_data, rd_data, d;
  logic signed [31:0] host_pos;
  logic [15:0]        host_org, host_bad;
  int                 failures, n_checks, net, n;
  logic [15:0]        ra [6] = '{`ADDR_PPR, `ADDR_LIN_RES, `ADDR_ORIGIN_DIR,
                                 `ADDR_ENC_RES, `ADDR_DIR_REV, 16'h1234};
  word_t              rv [6] = '{`RST_PPR, `RST_LIN_RES, 32'h0,
                                 `RST_ENC_RES, 32'h0, 32'h0};

  encoder_divided_quadrature_output dut (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .enc_step(enc_step),
    .enc_dir_up(enc_dir_up), .enc_origin(enc_origin),
    .quad_phase_a_out(pa), .quad_phase_a_out_n(pa_n),
    .quad_phase_b_out(pb), .quad_phase_b_out_n(pb_n),
    .origin_pulse_out(pc), .origin_pulse_out_n(pc_n));
  quad_host host (
    .clk(clk), .rst_n(rst_n), .pha(pa), .pha_n(pa_n), .phb(pb),
    .phb_n(pb_n), .org(pc), .org_n(pc_n), .pos(host_pos),
    .org_cnt(host_org), .bad_cnt(host_bad));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic word_t ab(input logic [1:0] s);
    return {30'h0, s[1], s[1] ^ s[0]};
  endfunction

  task automatic chk(input word_t got, input word_t exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input word_t v);
    @(posedge clk);
    wr_en <= 1'b1; addr <= a; wr_data <= v;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a);
    @(posedge clk);
    rd_en <= 1'b1; addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask

  task automatic steps(input int k, input logic up);
    @(posedge clk);
    enc_step <= 1'b1; enc_dir_up <= up;
    repeat (k) @(posedge clk);
    enc_step <= 1'b0;
    #1 net += up ? k : -k;
  endtask

  task automatic mark(input logic up);
    @(posedge clk);
    enc_origin <= 1'b1; enc_dir_up <= up;
    @(posedge clk);
    enc_origin <= 1'b0;
    #1;
  endtask

  task automatic end_sim;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    failures++;
    end_sim;
  end

  initial begin
    rst_n = 1'b0; wr_en = 1'b0; rd_en = 1'b0; addr = 16'h0;
    wr_data = 32'h0; enc_step = 1'b0; enc_dir_up = 1'b1; enc_origin = 1'b0;
    failures = 0; n_checks = 0; net = 0;
    d = $urandom(32'h79a0);
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(ra[i]);
      chk(d, rv[i]);
    end
    n = $urandom | 32'h1;
    wr(`ADDR_DIR_REV, n);
    rd(`ADDR_DIR_REV);
    chk(d, n & 32'hffff);
    wr(`ADDR_ENC_RES, 32'h10);
    wr(`ADDR_PPR, 32'h4);
    wr(`ADDR_CTRL, 32'h1);
    for (int i = 0; i < 40; i++) begin
      n = 1 + $urandom_range(2);
      steps(n, $urandom_range(1));
      chk({30'h0, pa, pb}, ab(net[1:0]));
    end
    wr(`ADDR_ENC_RES, 32'h20);
    wr(`ADDR_CTRL, 32'h1);
    steps(9, 1'b1);
    net -= 5;
    chk({30'h0, pa, pb}, ab(net[1:0]));
    wr(`ADDR_ENC_RES, 32'h10);
    wr(`ADDR_CTRL, 32'h1);
    // motor has turned many counts before homing
    mark(1'b1);
    chk(pc, 1);
    steps(1, 1'b1);
    chk(pc, 1);
    steps(1, 1'b1);
    chk(pc, 0);
    wr(`ADDR_LIN_RES, 32'h4);
    wr(`ADDR_PITCH_CNT, 32'h4);
    wr(`ADDR_CTRL, 32'h2);
    wr(`ADDR_CTRL, 32'h3);
    for (int r = 0; r < 2; r++) begin
      mark(1'b0);
      repeat (3) @(posedge clk);
      #1 chk(pc, 0);
      mark(1'b1);
      chk(pc, 1);
      steps(2, 1'b1);
      mark(1'b0);
      chk(pc, 1);
      steps(2, 1'b0);
      wr(`ADDR_CTRL, 32'h3);
    end
    wr(`ADDR_ORIGIN_DIR, 32'h1);
    wr(`ADDR_LIN_RES, 32'h10);
    wr(`ADDR_PITCH_CNT, 32'h10);
    wr(`ADDR_CTRL, 32'h3);
    mark(1'b0);
    chk(pc, 0);
    steps(2, 1'b0);
    @(posedge clk);
    #1 chk(pc, 1);
    steps(1, 1'b0);
    chk(pc, 0);
    // direction change during the eighth-pitch wait drops the mark
    mark(1'b0);
    steps(1, 1'b0);
    steps(1, 1'b1);
    chk(pc, 0);
    rd(`ADDR_STATUS);
    chk(d[3:0], {2'b10, net[1:0]});
    // pitch too short for a shift: narrow pulse starts at once
    wr(`ADDR_PITCH_CNT, 32'h4);
    wr(`ADDR_LIN_RES, 32'h4);
    wr(`ADDR_CTRL, 32'h3);
    mark(1'b1);
    chk(pc, 1);
    steps(1, 1'b1);
    chk(pc, 0);
    repeat (2) @(posedge clk);
    chk(host_pos, net);
    chk(host_bad, 0);
    chk(host_org, 7);
    end_sim;
  end
endmodule
